// *** rnpc_top.sv ***
/*
  rnpc_top: control of the dual-purpose reset / nmi pin, with Avalon-MM
  register access, pull resistor control, edge nmi and pulse reset output.
  Assumes: pin_in already buffered from the pad; brownout_class_reset is
  consumed by the device reset controller; one clock, mclk at 125 MHz.
*/
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module rnpc_top #(
  parameter int QUAL_CYC  = rnpc_pkg::RNPC_QUAL_CYC,
  parameter int RST_PULSE = rnpc_pkg::RNPC_RST_PULSE
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 ce,
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output var  logic [31:0]          avs_readdata,
  output var  logic                 avs_waitrequest,
  input  wire logic                 pin_in,
  output var  rnpc_pkg::rnpc_pull_t pin_pull,
  output var  logic                 brownout_class_reset,
  output var  logic                 nmi_request
);
  import rnpc_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (QUAL_CYC < 1 || QUAL_CYC > 255) begin : g_bad_qual
    $error("QUAL_CYC out of range");
  end
  if (RST_PULSE < 1 || RST_PULSE > 255) begin : g_bad_pulse
    $error("RST_PULSE out of range");
  end

  // ************************************************************
  // state
  // ************************************************************
  rnpc_ctrl_t ctrl_reg;
  logic       flag_reg;
  logic       pin_s;
  logic       pin_d_reg;
  logic [7:0] low_cnt_reg;
  logic [7:0] pulse_cnt_reg;
  logic       rst_armed_reg;
  logic       ack_reg;
  logic       edge_hit;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       req;

  rnpc_sync u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ce    (ce),
    .din   (pin_in),
    .dout  (pin_s)
  );

  // ************************************************************
  // bus slave: one wait cycle, answer on the second edge
  // ************************************************************
  assign req     = avs_read | avs_write;
  assign wr_ctrl = avs_write && ack_reg && avs_byteenable[0]
                   && avs_address == RNPC_CTRL_OFS;
  assign wr_stat = avs_write && ack_reg && avs_byteenable[0]
                   && avs_address == RNPC_STATUS_OFS;

  // ack_reg high for one cycle per request; waitrequest is its inverse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      ack_reg         <= req && !ack_reg;
      avs_waitrequest <= !(req && !ack_reg);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0;
    end else if (ce) begin
      if (avs_read && !ack_reg) begin
        if (avs_address == RNPC_CTRL_OFS) begin
          avs_readdata <= {27'h0, ctrl_reg};
        end else if (avs_address == RNPC_STATUS_OFS) begin
          avs_readdata <= {30'h0, pin_s, flag_reg};
        end else begin
          avs_readdata <= 32'h0;
        end
      end
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= rnpc_ctrl_t'(RNPC_CTRL_RST);
    end else if (ce && wr_ctrl) begin
      ctrl_reg <= rnpc_ctrl_t'(avs_writedata[4:0]);
    end
  end

  // ************************************************************
  // pull resistor drive
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_pull <= '{pull_en: 1'b1, pull_up: 1'b1};
    end else if (ce) begin
      pin_pull.pull_en <= ctrl_reg.pull_resistor_enable;
      pin_pull.pull_up <= ctrl_reg.pull_direction_select;
    end
  end

  // ************************************************************
  // edge nmi
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_d_reg <= 1'b1;
    end else if (ce) begin
      pin_d_reg <= pin_s;
    end
  end

  // edge select 0 = rising, 1 = falling
  assign edge_hit = ctrl_reg.interrupt_function_select &&
                    (ctrl_reg.interrupt_edge_select
                       ? (pin_d_reg && !pin_s)
                       : (!pin_d_reg && pin_s));

  // set wins over a simultaneous software clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= 1'b0;
    end else if (ce) begin
      if (edge_hit) begin
        flag_reg <= 1'b1;
      end else if (wr_stat && avs_writedata[RNPC_FLAG_BIT]) begin
        flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_request <= 1'b0;
    end else if (ce) begin
      nmi_request <= flag_reg && ctrl_reg.ext_interrupt_enable;
    end
  end

  // ************************************************************
  // reset function: low width qualification, then a pulse
  // ************************************************************
  // armed only after pin_s has been seen high, but pin_s resets high, so a pin held low
  // through rst_b still arms and gives a reset pulse after every rst_b
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_reg   <= 8'h0;
      rst_armed_reg <= 1'b0;
    end else if (ce) begin
      if (ctrl_reg.interrupt_function_select || pin_s) begin
        low_cnt_reg   <= 8'h0;
        rst_armed_reg <= pin_s;
      end else if (rst_armed_reg && low_cnt_reg != 8'(QUAL_CYC)) begin
        low_cnt_reg <= low_cnt_reg + 8'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_cnt_reg        <= 8'h0;
      brownout_class_reset <= 1'b0;
    end else if (ce) begin
      if (low_cnt_reg == 8'(QUAL_CYC - 1) && !pin_s && rst_armed_reg
          && !ctrl_reg.interrupt_function_select) begin
        pulse_cnt_reg        <= 8'(RST_PULSE);
        brownout_class_reset <= 1'b1;
      end else if (pulse_cnt_reg != 8'h0) begin
        pulse_cnt_reg        <= pulse_cnt_reg - 8'h1;
        brownout_class_reset <= (pulse_cnt_reg != 8'h1);
      end else begin
        brownout_class_reset <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** rnpc_pkg.sv ***
/*
  rnpc_pkg: constants and carrier types for the reset/nmi pin control block.
  Assumes: included before the design modules; 32-bit Avalon-MM data.
*/
package rnpc_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [3:0] RNPC_CTRL_OFS   = 4'h0;
  localparam logic [3:0] RNPC_STATUS_OFS = 4'h4;

  // ************************************************************
  // field positions in the control register
  // ************************************************************
  localparam int RNPC_FUNC_SEL_BIT  = 0;
  localparam int RNPC_EDGE_SEL_BIT  = 1;
  localparam int RNPC_INT_EN_BIT    = 2;
  localparam int RNPC_PULL_DIR_BIT  = 3;
  localparam int RNPC_PULL_EN_BIT   = 4;

  // ************************************************************
  // field positions in the status register
  // ************************************************************
  localparam int RNPC_FLAG_BIT      = 0;
  localparam int RNPC_PIN_BIT       = 1;

  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [4:0] RNPC_CTRL_RST   = 5'h18;
  localparam int         RNPC_QUAL_CYC   = 4;
  localparam int         RNPC_RST_PULSE  = 16;

  typedef struct packed {
    logic pull_resistor_enable;
    logic pull_direction_select;
    logic ext_interrupt_enable;
    logic interrupt_edge_select;
    logic interrupt_function_select;
  } rnpc_ctrl_t;

  typedef struct packed {
    logic pull_en;
    logic pull_up;
  } rnpc_pull_t;

endpackage

// *** rnpc_sync.sv ***
/*
  rnpc_sync: two-stage synchroniser for the pin level.
  Assumes: a single clock domain; ce freezes both stages.
*/
`timescale 1ns/1ns
`default_nettype none
module rnpc_sync (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic din,
  output var  logic dout
);
  logic meta_reg;

  // reset to high: the pin idles high under its default pull-up
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b1;
      dout     <= 1'b1;
    end else if (ce) begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** rnpc_pin_src.sv ***
/* rnpc_pin_src: board-side source on the dual-purpose pin.
   Assumes: pull state comes from the block under test. */
`timescale 1ns/1ns
`default_nettype none
module rnpc_pin_src (
  input  wire logic                 drv_en,
  input  wire logic                 drv_val,
  input  wire rnpc_pkg::rnpc_pull_t pull,
  output var  logic                 pin
);
  import rnpc_pkg::*;
  // released pin follows the resistor; floating pin shows no stale level
  always_comb pin = drv_en ? drv_val
                  : (pull.pull_en ? pull.pull_up : !drv_val);
endmodule
`default_nettype wire

// *** rnpc_top_checker.sv ***
/* rnpc_top_checker: port assertions for rnpc_top.
   Assumes: bound to rnpc_top; ce held high by the bench. */
`timescale 1ns/1ns
`default_nettype none
module rnpc_top_checker #(
  parameter int QUAL_CYC  = 4,
  parameter int RST_PULSE = 16
) (
  input wire logic                 mclk,
  input wire logic                 rst_b,
  input wire logic [3:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_writedata,
  input wire logic [3:0]           avs_byteenable,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic                 pin_in,
  input wire rnpc_pkg::rnpc_pull_t pin_pull,
  input wire logic                 brownout_class_reset,
  input wire logic                 nmi_request
);
  import rnpc_pkg::*;
  logic [4:0] ctrl_sh;
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ************
  // shadow state
  // ************
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b) ctrl_sh <= 5'h18;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h0
             && avs_byteenable[0]) ctrl_sh <= avs_writedata[4:0];
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b) hi_cnt <= 8'h00;
    else hi_cnt <= brownout_class_reset ? hi_cnt + 8'h01 : 8'h00;
  // saturates so a long low never wraps back under the threshold
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b) lo_cnt <= 8'h00;
    else lo_cnt <= pin_in ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
  // ******
  // checks
  // ******
  chk_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered");
  chk_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack longer than one cycle");
  chk_hole_zero: assert property (!avs_waitrequest && avs_read
    && avs_address != 4'h0 && avs_address != 4'h4 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_pull_track: assert property (ctrl_sh == $past(ctrl_sh)
    |-> pin_pull == {ctrl_sh[4], ctrl_sh[3]}) else $error("pull mismatch");
  chk_nmi_mask: assert property (!ctrl_sh[2] && !$past(ctrl_sh[2])
    |-> !nmi_request) else $error("nmi while disabled");
  chk_pulse_len: assert property ($fell(brownout_class_reset)
    |-> hi_cnt == RST_PULSE) else $error("reset pulse length");
  chk_reset_qual: assert property ($rose(brownout_class_reset)
    |-> !ctrl_sh[0] && $past(lo_cnt, 3) >= QUAL_CYC - 1)
    else $error("reset without qualified low");
  chk_nmi_edge: assert property (ctrl_sh[0] && ctrl_sh[2]
    && (ctrl_sh[1] ? $fell(pin_in) : $rose(pin_in)) |-> ##[2:6] nmi_request)
    else $error("edge gave no nmi");
  cov_reset: cover property ($rose(brownout_class_reset));
  cov_nmi: cover property ($rose(nmi_request));
  cov_write: cover property (!avs_waitrequest && avs_write);
endmodule
bind rnpc_top rnpc_top_checker #(.QUAL_CYC(QUAL_CYC), .RST_PULSE(RST_PULSE))
  i_chk (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_pull(pin_pull),
  .brownout_class_reset(brownout_class_reset), .nmi_request(nmi_request));
`default_nettype wire

// *** tb_top.sv ***
/* tb_top: register-level tests of rnpc_top with a pin source model.
   Assumes: short qualify and pulse counts set by parameter. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import rnpc_pkg::*;
  localparam int QC = 2;
  localparam int RP = 5;
  logic mclk, rst_b, rd, wr, wreq, pin, bcr, nmi, drv_en, drv_val;
  logic [3:0] adr;
  logic [31:0] wdata, rdata;
  rnpc_pull_t pull;
  int num_errors = 0;
  int n_compared = 0;
  rnpc_top #(.QUAL_CYC(QC), .RST_PULSE(RP)) i_dut (.mclk(mclk),
    .rst_b(rst_b), .ce(1'b1), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .pin_in(pin),
    .pin_pull(pull), .brownout_class_reset(bcr), .nmi_request(nmi));
  rnpc_pin_src i_src (.drv_en(drv_en), .drv_val(drv_val), .pull(pull),
    .pin(pin));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = !mclk;
  end
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus cycle; values read just after the edge are the sampled ones
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge mclk);
    rd <= !w; wr <= w; adr <= a; wdata <= d;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
      if (i > 20) begin
        num_errors++;
        complete_run();
      end
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic pin_to(input logic v, input int n);
    drv_en <= 1'b1; drv_val <= v;
    repeat (n) @(posedge mclk);
  endtask
  initial begin
    int i;
    rst_b = 1'b0; rd = 1'b0; wr = 1'b0; adr = 4'h0; wdata = 32'h0;
    drv_en = 1'b0; drv_val = 1'b1;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    chk("pull", {30'h0, pull}, 32'h3);
    rchk("ctrl", RNPC_CTRL_OFS, 32'h18);
    rchk("hole", 4'hc, 32'h0);
    drv_en <= 1'b1; drv_val <= 1'b0;
    for (i = 0; bcr !== 1'b1; i++) begin
      if (i > 40) begin
        num_errors++;
        complete_run();
      end
      @(posedge mclk);
    end
    for (i = 0; bcr === 1'b1 && i < 100; i++) @(posedge mclk);
    chk("pulse", i, RP);
    pin_to(1'b1, 4);
    wreg(RNPC_CTRL_OFS, 32'h1d);
    pin_to(1'b0, 10);
    chk("no reset", bcr, 1'b0);
    chk("fall ignored", nmi, 1'b0);
    pin_to(1'b1, 8);
    chk("nmi", nmi, 1'b1);
    rchk("flag", RNPC_STATUS_OFS, 32'h3);
    pin_to(1'b0, 4);
    pin_to(1'b1, 8);
    rchk("flag held", RNPC_STATUS_OFS, 32'h3);
    wreg(RNPC_STATUS_OFS, 32'h1);
    rchk("cleared", RNPC_STATUS_OFS, 32'h2);
    wreg(RNPC_CTRL_OFS, 32'h1f);
    pin_to(1'b0, 8);
    rchk("falling", RNPC_STATUS_OFS, 32'h1);
    wreg(RNPC_CTRL_OFS, 32'h19);
    wreg(RNPC_STATUS_OFS, 32'h1);
    pin_to(1'b1, 8);
    chk("masked", nmi, 1'b0);
    rchk("flag masked", RNPC_STATUS_OFS, 32'h3);
    for (i = 0; i < 4; i++) begin
      wreg(RNPC_CTRL_OFS, i << 3);
      repeat (2) @(posedge mclk);
      chk("pull sel", {30'h0, pull}, i);
    end
    // mid-run reset: control back to reset function, flag cleared
    wreg(RNPC_CTRL_OFS, 32'h1d);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rchk("ctrl again", RNPC_CTRL_OFS, 32'h18);
    rchk("stat again", RNPC_STATUS_OFS, 32'h2);
    complete_run();
  end
endmodule
`default_nettype wire
